// ### bench/tb.sv
// Self-checking bench for the parallel compare and word-bit execution unit.
// Assumes the unit answers one cycle after each strobe; its own assertions sit in the design files.
`timescale 1ns/10ps
module tb;
    typedef struct packed {
        logic [8:0] code;   // Instruction code.
        logic wide;         // 32-bit form.
        logic [31:0] a;     // Source 1, high word first.
        logic [31:0] b;     // Source 2, high word first.
        logic rung;         // Incoming rung result.
        logic exp;          // Expected rung result.
    } pcbo_row_type;
    logic clock;
    logic rstn;
    logic op_valid;
    pcbo_pkg::pcbo_op_type op;
    logic res_valid;
    pcbo_pkg::pcbo_res_type res;
    logic contact_no;
    logic contact_nc;
    logic error_led;
    int num_errors = 0;
    int total_checks = 0;
    pcbo_row_type rows [12];
    pcbo_pkg::pcbo_op_type o;
    logic [7:0] cnt_num [4];
    logic [3:0] cnt_wide;
    logic [3:0] cnt_err;

    pcbo_exec i_dut (
        .clock(clock),
        .rstn(rstn),
        .op_valid(op_valid),
        .op(op),
        .res_valid(res_valid),
        .res(res),
        .contact_no(contact_no),
        .contact_nc(contact_nc),
        .error_led(error_led)
    );

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic pcbo_pkg::pcbo_op_type mk(input logic [8:0] code, input logic wide, input logic [31:0] a,
        input logic [31:0] b, input logic rung, input logic [4:0] idx, input logic [31:0] dst);
        pcbo_pkg::pcbo_op_type r;
        r = '0;
        r.code = code;
        r.wide = wide;
        {r.s1_hi, r.s1_lo} = a;
        {r.s2_hi, r.s2_lo} = b;
        r.rung_in = rung;
        r.bit_index = idx;
        {r.dst_hi, r.dst_lo} = dst;
        return r;
    endfunction : mk

    // One instruction, then the result is sampled mid-cycle so that edge updates have landed.
    task automatic run(input pcbo_pkg::pcbo_op_type x);
        @(posedge clock);
        op_valid <= 1'b1;
        op <= x;
        @(posedge clock);
        op_valid <= 1'b0;
        @(negedge clock);
        check("res_valid", {31'h0, res_valid}, 32'h1);
    endtask : run

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    initial
    begin
        repeat (2000) @(posedge clock);
        num_errors++;
        $display("ERROR watchdog expected finish seen hang");
        end_sim();
    end

    initial
    begin
        rstn = 1'b0;
        op_valid = 1'b0;
        op = '0;
        // The first narrow row carries junk in the high word of source 1 to prove it is ignored.
        rows = '{'{pcbo_pkg::CODE_EQ, 1'b0, 32'h0001_0005, 32'h0000_0005, 1'b0, 1'b1},
                 '{pcbo_pkg::CODE_EQ, 1'b0, 32'h0000_0005, 32'h0000_0006, 1'b0, 1'b0},
                 '{pcbo_pkg::CODE_GT, 1'b0, 32'h0000_ffff, 32'h0000_0001, 1'b0, 1'b0},
                 '{pcbo_pkg::CODE_LT, 1'b0, 32'h0000_ffff, 32'h0000_0001, 1'b0, 1'b1},
                 '{pcbo_pkg::CODE_NE, 1'b0, 32'h0000_0003, 32'h0000_0003, 1'b0, 1'b0},
                 '{pcbo_pkg::CODE_LE, 1'b0, 32'h0000_8000, 32'h0000_7fff, 1'b0, 1'b1},
                 '{pcbo_pkg::CODE_GE, 1'b0, 32'h0000_7fff, 32'h0000_8000, 1'b0, 1'b1},
                 '{pcbo_pkg::CODE_GE, 1'b1, 32'h0001_0000, 32'h0000_ffff, 1'b0, 1'b1},
                 '{pcbo_pkg::CODE_LT, 1'b1, 32'hffff_ffff, 32'h0000_0001, 1'b0, 1'b1},
                 '{pcbo_pkg::CODE_EQ, 1'b0, 32'h0000_0001, 32'h0000_0002, 1'b1, 1'b1},
                 '{pcbo_pkg::CODE_NE, 1'b1, 32'h0001_0005, 32'h0000_0005, 1'b0, 1'b1},
                 '{pcbo_pkg::CODE_GT, 1'b1, 32'h0000_0002, 32'h0000_0001, 1'b0, 1'b1}};
        cnt_num = '{8'hc8, 8'hc8, 8'hfe, 8'hc7};
        cnt_wide = 4'h2;
        cnt_err = 4'h5;
        repeat (20) @(posedge clock);
        check("res_valid_rst", {31'h0, res_valid}, 32'h0);
        check("contact_nc_rst", {31'h0, contact_nc}, 32'h1);
        check("error_led_rst", {31'h0, error_led}, 32'h0);
        rstn <= 1'b1;
        $display("reset test done");
        foreach (rows[i])
        begin
            run(mk(rows[i].code, rows[i].wide, rows[i].a, rows[i].b, rows[i].rung, 5'h00, 32'h0));
            check("rung_out", {31'h0, res.rung_out}, {31'h0, rows[i].exp});
        end
        $display("compare table done");
        run(mk(pcbo_pkg::CODE_BIT_OUTPUT, 1'b0, 32'h0, 32'h0, 1'b1, 5'h03, 32'h0));
        check("bit_out_on", {res.dst_hi, res.dst_lo}, 32'h0000_0008);
        check("contact_no_on", {31'h0, contact_no}, 32'h1);
        run(mk(pcbo_pkg::CODE_BIT_OUTPUT, 1'b0, 32'h0, 32'h0, 1'b0, 5'h03, 32'h0000_ffff));
        check("bit_out_off", {res.dst_hi, res.dst_lo}, 32'h0000_fff7);
        check("contact_nc_off", {31'h0, contact_nc}, 32'h1);
        run(mk(pcbo_pkg::CODE_BIT_SET, 1'b1, 32'h0, 32'h0, 1'b1, 5'h1f, 32'h0000_1234));
        check("set_wide_31", {res.dst_hi, res.dst_lo}, 32'h8000_1234);
        check("set_write", {31'h0, res.dst_write}, 32'h1);
        run(mk(pcbo_pkg::CODE_BIT_SET, 1'b0, 32'h0, 32'h0, 1'b0, 5'h05, 32'h0));
        check("set_latched", {31'h0, contact_no}, 32'h1);
        check("set_idle_write", {31'h0, res.dst_write}, 32'h0);
        run(mk(pcbo_pkg::CODE_BIT_CLEAR, 1'b0, 32'h0, 32'h0, 1'b1, 5'h00, 32'h0000_ffff));
        check("clear_bit0", {res.dst_hi, res.dst_lo}, 32'h0000_fffe);
        check("clear_contact", {31'h0, contact_no}, 32'h0);
        run(mk(pcbo_pkg::CODE_BIT_SET, 1'b0, 32'h0, 32'h0, 1'b1, 5'h10, 32'h0));
        check("index_err_narrow", {30'h0, res.index_error, res.dst_write}, 32'h2);
        run(mk(pcbo_pkg::CODE_BIT_SET, 1'b1, 32'h0, 32'h0, 1'b1, 5'h10, 32'h0));
        check("index_ok_wide", {res.dst_hi, res.dst_lo}, 32'h0001_0000);
        check("index_err_wide", {31'h0, res.index_error}, 32'h0);
        run(mk(pcbo_pkg::CODE_BIT_CLEAR, 1'b1, 32'h0, 32'h0, 1'b1, 5'h1f, 32'hffff_ffff));
        check("clear_wide_31", {res.dst_hi, res.dst_lo}, 32'h7fff_ffff);
        run(mk(9'h0f3, 1'b0, 32'h0, 32'h0, 1'b1, 5'h00, 32'h0));
        check("other_code", {30'h0, res.rung_out, res.dst_write}, 32'h2);
        $display("word bit tests done");
        for (int i = 0; i < 4; i++)
        begin
            o = mk(pcbo_pkg::CODE_EQ, cnt_wide[i], 32'h5, 32'h5, 1'b0, 5'h00, 32'h0);
            o.s1_is_cnt = 1'b1;
            o.s1_cnt = cnt_num[i];
            run(o);
            check("prog_error", {31'h0, res.prog_error}, {31'h0, cnt_err[i]});
            check("err_rung_out", {31'h0, res.rung_out}, {31'h0, ~cnt_err[i]});
        end
        $display("counter width tests done");
        run(mk(pcbo_pkg::CODE_BIT_OUTPUT, 1'b1, 32'h0, 32'h0, 1'b1, 5'h1f, 32'h0));
        check("bit_out_wide", {res.dst_hi, res.dst_lo}, 32'h8000_0000);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        check("contact_no_rst2", {31'h0, contact_no}, 32'h0);
        check("contact_nc_rst2", {31'h0, contact_nc}, 32'h1);
        check("error_led_rst2", {31'h0, error_led}, 32'h0);
        rstn <= 1'b1;
        run(mk(pcbo_pkg::CODE_EQ, 1'b0, 32'h7, 32'h7, 1'b0, 5'h00, 32'h0));
        check("eq_after_rst", {31'h0, res.rung_out}, 32'h1);
        $display("second reset test done");
        end_sim();
    end
endmodule : tb

// ### core/pcbo_compare.sv
// Signed comparator for 16-bit and 32-bit operand pairs.
// Assumes operands are already assembled high word first; purely combinational.
`timescale 1ns/10ps
module pcbo_compare (
    input wire logic [31:0] a,   // Source 1.
    input wire logic [31:0] b,   // Source 2.
    input wire logic wide,       // Set for 32-bit compare.
    output logic eq,             // Sources equal.
    output logic lt              // Source 1 below source 2.
);
    wire signed [31:0] a_s;
    wire signed [31:0] b_s;

    // The narrow form is sign extended from bit 15.
    assign a_s = wide ? a : {{16{a[15]}}, a[15:0]};
    assign b_s = wide ? b : {{16{b[15]}}, b[15:0]};
    assign eq = (a_s == b_s);
    assign lt = (a_s < b_s);
endmodule : pcbo_compare

// ### core/pcbo_exec.sv
// Execution unit for parallel comparisons and word-bit output, set and clear.
// Assumes the sequencer holds op stable with op_valid and writes back result words.
`timescale 1ns/10ps
module pcbo_exec (
    input wire logic clock,                 // Scan clock, 250 MHz.
    input wire logic rstn,                  // Asynchronous reset, active low.
    input wire logic op_valid,              // Instruction present this cycle.
    input wire pcbo_pkg::pcbo_op_type op,   // Instruction operands.
    output logic res_valid,                 // Result present, one cycle.
    output pcbo_pkg::pcbo_res_type res,     // Instruction result.
    output logic contact_no,                // Open contact of last driven bit.
    output logic contact_nc,                // Closed contact of last driven bit.
    output logic error_led                  // Error indicator, flashes while set.
);

    function automatic logic is_wide_cnt(input logic present, input logic [7:0] num);
        is_wide_cnt = present && (num >= pcbo_pkg::WIDE_CNT_FIRST) && (num <= pcbo_pkg::WIDE_CNT_LAST);
    endfunction : is_wide_cnt

    wire [31:0] src1;
    wire [31:0] src2;
    wire [31:0] dst_word;
    wire cmp_eq;
    wire cmp_lt;
    wire is_cmp;
    wire is_bit;
    wire test_true;
    wire bad_counter;
    wire index_ok;
    wire [31:0] bit_mask;
    wire [31:0] dst_new;
    wire bit_value;
    wire flash_wrap;

    logic res_valid_reg;
    pcbo_pkg::pcbo_res_type res_reg;
    pcbo_pkg::pcbo_res_type res_next;
    logic contact_no_reg;
    logic contact_nc_reg;
    logic err_latched_reg;
    logic [23:0] flash_cnt_reg;
    logic error_led_reg;

    assign src1 = {op.wide ? op.s1_hi : 16'h0000, op.s1_lo};
    assign src2 = {op.wide ? op.s2_hi : 16'h0000, op.s2_lo};
    assign dst_word = {op.dst_hi, op.dst_lo};

    pcbo_compare u_compare (
        .a(src1),
        .b(src2),
        .wide(op.wide),
        .eq(cmp_eq),
        .lt(cmp_lt)
    );

    assign is_cmp = (op.code == pcbo_pkg::CODE_EQ) || (op.code == pcbo_pkg::CODE_GT) ||
                    (op.code == pcbo_pkg::CODE_LT) || (op.code == pcbo_pkg::CODE_NE) ||
                    (op.code == pcbo_pkg::CODE_LE) || (op.code == pcbo_pkg::CODE_GE);
    assign is_bit = (op.code == pcbo_pkg::CODE_BIT_OUTPUT) || (op.code == pcbo_pkg::CODE_BIT_SET) ||
                    (op.code == pcbo_pkg::CODE_BIT_CLEAR);

    // Relation decode; each discontinuity case is the complement of its test.
    assign test_true = (op.code == pcbo_pkg::CODE_EQ) ? cmp_eq :
                       (op.code == pcbo_pkg::CODE_GT) ? (!cmp_eq && !cmp_lt) :
                       (op.code == pcbo_pkg::CODE_LT) ? cmp_lt :
                       (op.code == pcbo_pkg::CODE_NE) ? !cmp_eq :
                       (op.code == pcbo_pkg::CODE_LE) ? (cmp_eq || cmp_lt) :
                       (op.code == pcbo_pkg::CODE_GE) ? !cmp_lt : 1'b0;

    // A 32-bit counter used in the narrow form is a program error.
    assign bad_counter = is_cmp && !op.wide &&
                         (is_wide_cnt(op.s1_is_cnt, op.s1_cnt) || is_wide_cnt(op.s2_is_cnt, op.s2_cnt));

    // Index range depends on the form.
    assign index_ok = op.wide ? (op.bit_index <= pcbo_pkg::WIDE_INDEX_MAX)
                              : (op.bit_index <= pcbo_pkg::NARROW_INDEX_MAX);

    // Set drives the bit on when its rung is true; clear drops it, and output follows the rung.
    assign bit_value = (op.code == pcbo_pkg::CODE_BIT_OUTPUT) ? op.rung_in :
                       (op.code == pcbo_pkg::CODE_BIT_SET) ? 1'b1 : 1'b0;

    // One slice per destination bit, so that no write can disturb a bit that was not indexed.
    generate
        for (genvar k = 0; k < 32; k++)
        begin : g_bit
            assign bit_mask[k] = (op.bit_index == 5'(k));
            assign dst_new[k] = bit_mask[k] ? bit_value : dst_word[k];
        end
    endgenerate

    always_comb
    begin
        res_next = '0;
        res_next.rung_out = op.rung_in;
        if (is_cmp)
        begin
            // The comparison is a branch in parallel with earlier contacts.
            res_next.rung_out = op.rung_in | (test_true & !bad_counter);
            res_next.prog_error = bad_counter;
        end
        else if (is_bit)
        begin
            res_next.index_error = !index_ok;
            // A set or clear only acts when its rung is true; output acts on either rung.
            res_next.dst_write = index_ok && ((op.code == pcbo_pkg::CODE_BIT_OUTPUT) || op.rung_in);
            res_next.dst_lo = res_next.dst_write ? dst_new[15:0] : op.dst_lo;
            res_next.dst_hi = res_next.dst_write ? (op.wide ? dst_new[31:16] : op.dst_hi) : op.dst_hi;
        end
    end

    // The result stands one cycle only and clears to zero unless another answer follows, so the sequencer must copy it in that cycle.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            res_valid_reg <= 1'b0;
            res_reg <= '0;
        end
        else
        begin
            res_valid_reg <= op_valid;
            res_reg <= op_valid ? res_next : '0;
        end
    end

    // Contacts mirror the last written bit; stale until the next bit instruction that writes its destination.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            contact_no_reg <= 1'b0;
            contact_nc_reg <= 1'b1;
        end
        else if (op_valid && res_next.dst_write)
        begin
            contact_no_reg <= bit_value;
            contact_nc_reg <= !bit_value;
        end
    end

    // The indicator toggles each time the counter wraps.
    assign flash_wrap = (flash_cnt_reg == pcbo_pkg::FLASH_HALF);

    // The program error stays latched until reset, as the controller halts on it.
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            err_latched_reg <= 1'b0;
            flash_cnt_reg <= 24'h00_0000;
            error_led_reg <= 1'b0;
        end
        else
        begin
            if (op_valid && bad_counter)
            begin
                err_latched_reg <= 1'b1;
            end
            if (err_latched_reg)
            begin
                flash_cnt_reg <= flash_wrap ? 24'h00_0000 : flash_cnt_reg + 24'h00_0001;
                if (flash_wrap)
                begin
                    error_led_reg <= !error_led_reg;
                end
            end
        end
    end

    assign res_valid = res_valid_reg;
    assign res = res_reg;
    assign contact_no = contact_no_reg;
    assign contact_nc = contact_nc_reg;
    assign error_led = error_led_reg;

    a_contacts_opposite: assert property (@(posedge clock) disable iff (!rstn) contact_no != contact_nc)
        else $error("contacts not complementary");
    a_rung_or_kept: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && is_cmp && op.rung_in |=> res.rung_out)
        else $error("rung true lost by compare");
    a_eq_result: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_EQ && !op.rung_in && !bad_counter |=> res.rung_out == $past(cmp_eq))
        else $error("equal compare wrong");
    a_ge_signed: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_GE && !op.rung_in && op.wide && !bad_counter
        |=> res.rung_out == ($signed($past(src1)) >= $signed($past(src2))))
        else $error("signed ge wrong");
    a_gt_code: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_GT && !op.rung_in && !bad_counter
        |=> res.rung_out == !($past(cmp_eq) || $past(cmp_lt)))
        else $error("greater compare wrong");
    a_bad_counter_err: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && bad_counter |=> res.prog_error ##1 err_latched_reg)
        else $error("program error not raised");
    a_index_range: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && is_bit && !op.wide && op.bit_index > pcbo_pkg::NARROW_INDEX_MAX |=> res.index_error && !res.dst_write)
        else $error("index range not checked");
    a_out_bit: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_BIT_OUTPUT && index_ok |=> contact_no == $past(op.rung_in))
        else $error("bit output wrong");
    a_set_bit: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_BIT_SET && op.rung_in && index_ok
        |=> res.dst_write && ((({res.dst_hi, res.dst_lo}) & $past(bit_mask)) != 32'h0000_0000))
        else $error("bit set wrong");
    a_clear_bit: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_BIT_CLEAR && op.rung_in && op.wide && index_ok
        |=> ((({res.dst_hi, res.dst_lo}) & $past(bit_mask)) == 32'h0000_0000))
        else $error("bit clear wrong");

    // Relations checked against signed arithmetic or the comparator outputs as they were taken; also high-word use and no destination write.
    a_lt_narrow: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_LT && !op.rung_in && !op.wide && !bad_counter
        |=> res.rung_out == ($signed($past(op.s1_lo)) < $signed($past(op.s2_lo))))
        else $error("less compare wrong");
    a_ne_code: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_NE && !op.rung_in && !bad_counter
        |=> res.rung_out == ($past(src1) != $past(src2)))
        else $error("not equal compare wrong");
    a_le_code: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_LE && !op.rung_in && !bad_counter
        |=> res.rung_out == ($past(cmp_lt) || $past(cmp_eq)))
        else $error("less or equal compare wrong");
    a_ge_narrow: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_GE && !op.rung_in && !op.wide && !bad_counter
        |=> res.rung_out == ($signed($past(op.s1_lo)) >= $signed($past(op.s2_lo))))
        else $error("narrow signed ge wrong");
    a_gt_wide: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_GT && !op.rung_in && op.wide && !bad_counter
        |=> res.rung_out == ($signed($past(src1)) > $signed($past(src2))))
        else $error("wide signed gt wrong");
    a_narrow_hi_ignored: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_EQ && !op.wide && !op.rung_in && !bad_counter && op.s1_lo == op.s2_lo
        |=> res.rung_out)
        else $error("narrow equal used high word");
    a_wide_high_word: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_NE && op.wide && !op.rung_in && op.s1_lo == op.s2_lo
        |=> res.rung_out == ($past(op.s1_hi) != $past(op.s2_hi)))
        else $error("wide compare ignored high word");
    a_compare_no_write: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && is_cmp |=> !res.dst_write && !res.index_error)
        else $error("compare wrote destination");

    a_error_dark: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && bad_counter && !op.rung_in |=> !res.rung_out)
        else $error("erroneous compare gave continuity");
    a_wide_no_error: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && is_cmp && op.wide |=> !res.prog_error)
        else $error("wide compare raised program error");
    a_led_dark: assert property (@(posedge clock) disable iff (!rstn)
        !err_latched_reg |-> !error_led)
        else $error("error indicator lit without error");
    a_flash_bound: assert property (@(posedge clock) disable iff (!rstn)
        flash_cnt_reg <= pcbo_pkg::FLASH_HALF)
        else $error("flash counter overran");
    a_narrow_index_ok: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && is_bit && !op.wide && op.bit_index <= pcbo_pkg::NARROW_INDEX_MAX |=> !res.index_error)
        else $error("narrow index refused");
    a_wide_index: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && is_bit && op.wide |=> !res.index_error)
        else $error("wide index refused");

    a_out_on: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_BIT_OUTPUT && index_ok && op.rung_in
        |=> res.dst_write &&
            (({res.dst_hi, res.dst_lo} & (32'h0000_0001 << $past(op.bit_index))) != 32'h0000_0000))
        else $error("bit output did not set");
    a_out_off: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_BIT_OUTPUT && index_ok && !op.rung_in
        |=> res.dst_write &&
            (({res.dst_hi, res.dst_lo} & (32'h0000_0001 << $past(op.bit_index))) == 32'h0000_0000))
        else $error("bit output did not clear");
    a_bit_rung_kept: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && is_bit |=> res.rung_out == $past(op.rung_in))
        else $error("bit instruction changed rung");
    a_contact_hold: assert property (@(posedge clock) disable iff (!rstn)
        !(op_valid && is_bit) |=> $stable(contact_no))
        else $error("contact moved without bit instruction");
    a_clear_contact: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_BIT_CLEAR && op.rung_in && index_ok |=> contact_nc && !contact_no)
        else $error("contacts wrong after clear");
    a_set_no_clear: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_BIT_SET
        |=> !res.dst_write ||
            (({res.dst_hi, res.dst_lo} & (32'h0000_0001 << $past(op.bit_index))) != 32'h0000_0000))
        else $error("bit set cleared its bit");
    a_clear_narrow: assert property (@(posedge clock) disable iff (!rstn)
        op_valid && op.code == pcbo_pkg::CODE_BIT_CLEAR && op.rung_in && !op.wide && index_ok
        |=> res.dst_write && res.dst_hi == $past(op.dst_hi) &&
            ((res.dst_lo & (16'h0001 << $past(op.bit_index))) == 16'h0000))
        else $error("narrow bit clear wrong");

    c_compare_true: cover property (@(posedge clock) op_valid && is_cmp && !op.rung_in && test_true);
    c_prog_error: cover property (@(posedge clock) op_valid && bad_counter);
    c_set_then_clear: cover property (@(posedge clock) op_valid && op.code == pcbo_pkg::CODE_BIT_SET
        ##[1:8] op_valid && op.code == pcbo_pkg::CODE_BIT_CLEAR);
    c_index_refused: cover property (@(posedge clock) op_valid && is_bit && !index_ok);
    c_wide_output: cover property (@(posedge clock) op_valid && op.code == pcbo_pkg::CODE_BIT_OUTPUT
        && op.wide && op.bit_index > pcbo_pkg::NARROW_INDEX_MAX);
endmodule : pcbo_exec

// ### pkg/pcbo_pkg.sv
// Shared types and constants for the parallel compare and word-bit execution block.
// Assumes the sequencer presents one instruction per valid strobe on the scan clock.
package pcbo_pkg;

    // Parallel comparison codes.
    localparam logic [8:0] CODE_EQ = 9'h0f0;
    localparam logic [8:0] CODE_GT = 9'h0f1;
    localparam logic [8:0] CODE_LT = 9'h0f2;
    localparam logic [8:0] CODE_NE = 9'h0f4;
    localparam logic [8:0] CODE_LE = 9'h0f5;
    localparam logic [8:0] CODE_GE = 9'h0f6;

    // Word-bit instruction codes.
    localparam logic [8:0] CODE_BIT_OUTPUT = 9'h10a;
    localparam logic [8:0] CODE_BIT_SET = 9'h10b;
    localparam logic [8:0] CODE_BIT_CLEAR = 9'h10c;

    // Counter numbers that hold 32-bit values.
    localparam logic [7:0] WIDE_CNT_FIRST = 8'hc8;
    localparam logic [7:0] WIDE_CNT_LAST = 8'hfe;

    localparam logic [4:0] NARROW_INDEX_MAX = 5'h0f;
    localparam logic [4:0] WIDE_INDEX_MAX = 5'h1f;
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // Error indicator half period in scan clocks, counted from zero.
    localparam logic [23:0] FLASH_HALF = 24'h7a_1200;

    typedef struct packed {
        logic [8:0] code;       // Instruction code.
        logic wide;             // Set for the 32-bit form.
        logic [15:0] s1_lo;     // Source 1 named register.
        logic [15:0] s1_hi;     // Source 1 next register.
        logic [15:0] s2_lo;     // Source 2 named register.
        logic [15:0] s2_hi;     // Source 2 next register.
        logic s1_is_cnt;        // Source 1 is a counter.
        logic [7:0] s1_cnt;     // Counter number of source 1.
        logic s2_is_cnt;        // Source 2 is a counter.
        logic [7:0] s2_cnt;     // Counter number of source 2.
        logic rung_in;          // Current rung result.
        logic [4:0] bit_index;  // Selected bit.
        logic [15:0] dst_lo;    // Destination named register.
        logic [15:0] dst_hi;    // Destination next register.
    } pcbo_op_type;

    typedef struct packed {
        logic [15:0] dst_lo;    // New destination low word.
        logic [15:0] dst_hi;    // New destination high word.
        logic dst_write;        // Destination words to be written.
        logic rung_out;         // Rung result after the instruction.
        logic prog_error;       // Program error pulse.
        logic index_error;      // Bit index out of range pulse.
    } pcbo_res_type;

endpackage : pcbo_pkg
